// ### common/mgs_phase_if.sv
// Purpose: phase samples in, per-phase power out
// Assumes: one sample set per valid pulse
// Notes: power width leaves room for the summed B voltage
`timescale 1ns/1ps
interface mgs_phase_if #(parameter int W = 16);
    logic valid;
    logic signed [W-1:0] va, vb, vc, ia, ib, ic;
    mgs_pkg::mgs_conn_e cfg;
    logic pvalid;
    logic signed [2*W+1:0] pa, pb, pc;
    modport src (output valid, va, vb, vc, ia, ib, ic, cfg,
                 input pvalid, pa, pb, pc);
    modport calc (input valid, va, vb, vc, ia, ib, ic, cfg,
                  output pvalid, pa, pb, pc);
endinterface

// ### common/mgs_pkg.sv
// Purpose: shared constants for the global status and mode registers
// Assumes: byte-wide registers at word offsets 0x000 to 0x002
// Notes: bit positions and masks are used by the design; the bench uses literal values
package mgs_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_OPM0 = 12'h001;
    localparam logic [11:0] ADDR_OPM1 = 12'h002;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int ST_XFAIL = 6;
    localparam int ST_POR = 5;
    localparam int ST_WDT = 4;
    localparam int ST_PHASE = 2;
    localparam int ST_PREV = 0;
    localparam int OP0_EXTERNAL_CLOCK_SELECT = 4;
    localparam int OP0_SOFTWARE_RESTART = 3;
    localparam int OP0_PROCESSING_DISABLE = 2;
    localparam int OP0_LOW_POWER_SELECT = 1;
    localparam int OP1_CRC = 3;
    localparam int OP1_POL = 2;
    localparam int OP1_CONN = 0;
    // ----------------------------------------------------------------
    // Masks, resets, timing
    // ----------------------------------------------------------------
    localparam logic [7:0] STATUS_MASK = 8'h75;
    localparam logic [7:0] OPM0_MASK = 8'h1e;
    localparam logic [7:0] OPM1_MASK = 8'h0f;
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] OPM0_RST = 8'h00;
    localparam logic [7:0] OPM1_RST = 8'h00;
    localparam int RING_OSC_HZ = 1000000;
    localparam int PULSE_W = 16;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        CONN_BRANCH = 2'b00,
        CONN_DELTA4 = 2'b01,
        CONN_WYE2 = 2'b10,
        CONN_DELTA3 = 2'b11
    } mgs_conn_e;
    typedef enum logic {PG_IDLE, PG_ACTIVE} mgs_pg_e;
endpackage

// ### dv/mgs_host_model.sv
// Purpose: host side of the register port
// Assumes: one-cycle strobes, changed after the clock edge
// Notes: idle address and data are scrambled so stale values never match
`timescale 1ns/1ps
module mgs_host_model (
    // Clock
    input wire logic clk,
    // Register port
    output logic [11:0] addr,
    output logic wr,
    output logic rd,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 12'hfff;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h5a;
    end
    task automatic write(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic read(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask
endmodule

// ### dv/test_metering_global_status_mode_regs.sv
// Purpose: self-checking bench for the status and mode registers
// Assumes: samples of 16 bits, two pulse outputs
// Notes: results are visible just after the edge that takes a request
`timescale 1ns/1ps
module test_metering_global_status_mode_regs;
    logic clk, reset_n, wr, rd, cfail, por, wdt, phrev, plrev, rdone, sv, pv;
    logic osc_en, pin_ck, fw_rst, pdis, ring, crc_en;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, v, d;
    logic [1:0] pev, pout;
    logic [15:0] pw;
    logic signed [15:0] va, vb, vc, ia, ib, ic;
    logic signed [33:0] pa, pb, pc;
    int err_count = 0;
    int n_compared = 0;
    mgs_host_model u_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata),
        .rdata(rdata));
    mgs_regs #(.W(16), .NP(2)) u_dut (.CLK(clk), .RESET_N(reset_n), .REG_ADDR(addr),
        .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .CRYSTAL_FAIL(cfail), .POR_EVENT(por), .WDT_EVENT(wdt), .PHASE_REVERSED(phrev),
        .PULSE_REVERSED(plrev), .RESTART_DONE(rdone), .CRYSTAL_OSC_EN(osc_en),
        .CRYSTAL_PIN_CLKIN(pin_ck), .FW_RESTART(fw_rst), .PROC_DISABLE(pdis),
        .RING_OSC_SEL(ring), .SERIAL_CHECK_EN(crc_en), .PULSE_EVENT(pev),
        .PULSE_WIDTH(pw), .ENERGY_PULSE_OUT(pout), .SAMPLE_VALID(sv), .VOLT_A(va),
        .VOLT_B(vb), .VOLT_C(vc), .CURR_A(ia), .CURR_B(ib), .CURR_C(ic),
        .POWER_VALID(pv), .POWER_A(pa), .POWER_B(pb), .POWER_C(pc));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic signed [33:0] pwr(input logic [1:0] c,
        input logic signed [33:0] a, b, cc, i);
        case (c)
            2'b00: return i * b;
            2'b01: return i * (-cc);
            2'b10: return i * (-a - cc);
            default: return i * (a - cc);
        endcase
    endfunction
    // ----------------------------------------------------------------
    // Clock, reset and stimulus
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500us;
        err_count++;
        wrap_up();
    end
    initial begin
        {reset_n, cfail, por, wdt, phrev, plrev, rdone, sv, pev} = '0;
        {va, vb, vc, ia, ib, ic, pw} = '0;
        void'($urandom(24959));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 chk({osc_en, pin_ck, fw_rst, pdis, ring, crc_en, pout}, 8'h83);
        for (int k = 0; k < 3; k++) begin
            u_host.read(12'(k), d);
            chk(d, 8'h00);
        end
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'hff : 8'($urandom);
            u_host.write(12'h001, v);
            u_host.read(12'h001, d);
            chk(d, v & 8'h1e);
            chk({osc_en, pin_ck, fw_rst, pdis, ring}, {~v[4], v[4:1]});
        end
        u_host.write(12'h001, 8'h08);
        @(posedge clk) rdone <= 1'b1;
        @(posedge clk) rdone <= 1'b0;
        #1 chk(fw_rst, 1'b0);
        u_host.read(12'h001, d);
        chk(d, 8'h00);
        @(posedge clk) {por, wdt} <= 2'b11;
        @(posedge clk) {por, wdt} <= 2'b00;
        u_host.read(12'h000, d);
        chk(d, 8'h30);
        u_host.write(12'h000, 8'h00);
        u_host.read(12'h000, d);
        chk(d, 8'h00);
        u_host.write(12'h000, 8'hcf);
        u_host.read(12'h000, d);
        chk(d, 8'h00);
        @(posedge clk) {cfail, phrev, plrev} <= 3'b111;
        u_host.write(12'h000, 8'h00);
        u_host.read(12'h000, d);
        chk(d, 8'h45);
        chk(ring, 1'b1);
        u_host.read(12'h003, d);
        chk(d, 8'h00);
        for (int c = 0; c < 4; c++) begin
            v = {4'h0, 1'($urandom), 1'(c), 2'(c)};
            pw <= 16'(c + 1);
            u_host.write(12'h002, v);
            #1 chk(crc_en, v[3]);
            @(posedge clk);
            {va, vb, vc, ia, ib, ic} <= {$urandom, $urandom, $urandom};
            sv <= 1'b1;
            @(posedge clk) sv <= 1'b0;
            #1 chk(pv, 1'b1);
            chk(pa, pwr(2'b00, 0, va, 0, ia));
            chk(pc, pwr(2'b00, 0, vc, 0, ic));
            chk(pb, pwr(2'(c), va, vb, vc, ib));
            @(posedge clk) pev <= 2'b01;
            #1 chk(pv, 1'b0);
            @(posedge clk) pev <= 2'b00;
            repeat (c + 1) begin
                #1 chk(pout, {~v[2], v[2]});
                @(posedge clk);
            end
            #1 chk(pout, {~v[2], ~v[2]});
        end
        wrap_up();
    end
endmodule

// ### hdl/mgs_power_calc.sv
// Purpose: per-phase power from the connection setting
// Assumes: samples are signed two's complement
// Notes: one cycle latency, result held between samples
`timescale 1ns/1ps
module mgs_power_calc (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Phase data
    mgs_phase_if.calc ph
);
    localparam int PW = $bits(ph.pa);
    logic signed [PW-1:0] va_x, vb_x, vc_x, ia_x, ib_x, ic_x, vb_eff;
    logic signed [PW-1:0] pa_r, pb_r, pc_r, pa_nxt, pb_nxt, pc_nxt;
    logic pv_r, pv_nxt;

    always_comb begin
        va_x = PW'(ph.va);
        vb_x = PW'(ph.vb);
        vc_x = PW'(ph.vc);
        ia_x = PW'(ph.ia);
        ib_x = PW'(ph.ib);
        ic_x = PW'(ph.ic);
        case (ph.cfg)
            // RULE17: split leg uses minus C
            mgs_pkg::CONN_DELTA4: vb_eff = -vc_x;
            // RULE18: B is minus A minus C
            mgs_pkg::CONN_WYE2: vb_eff = -va_x - vc_x;
            // RULE19: B is A minus C
            mgs_pkg::CONN_DELTA3: vb_eff = va_x - vc_x;
            // RULE16: own voltage per branch
            default: vb_eff = vb_x;
        endcase
        pa_nxt = pa_r;
        pb_nxt = pb_r;
        pc_nxt = pc_r;
        pv_nxt = ph.valid;
        if (ph.valid) begin
            pa_nxt = ia_x * va_x;
            pb_nxt = ib_x * vb_eff;
            pc_nxt = ic_x * vc_x;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pa_r <= '0;
            pb_r <= '0;
            pc_r <= '0;
            pv_r <= 1'b0;
        end else begin
            pa_r <= pa_nxt;
            pb_r <= pb_nxt;
            pc_r <= pc_nxt;
            pv_r <= pv_nxt;
        end
    end
    assign ph.pa = pa_r;
    assign ph.pb = pb_r;
    assign ph.pc = pc_r;
    assign ph.pvalid = pv_r;
endmodule

// ### hdl/mgs_pulse_gen.sv
// Purpose: one energy pulse output with selectable polarity
// Assumes: width counted in clock cycles, zero acts as one
// Notes: events during an active pulse are dropped
`timescale 1ns/1ps
module mgs_pulse_gen #(parameter int WW = mgs_pkg::PULSE_W) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control
    input wire logic pol,
    input wire logic [WW-1:0] width,
    input wire logic evt,
    // Pin
    output logic pout
);
    mgs_pkg::mgs_pg_e st_r, st_nxt;
    logic [WW-1:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        case (st_r)
            mgs_pkg::PG_IDLE: begin
                // RULE14: idle at inverse level
                out_nxt = !pol;
                if (evt) begin
                    st_nxt = mgs_pkg::PG_ACTIVE;
                    // RULE15: drive active level
                    out_nxt = pol;
                    cnt_nxt = (width == '0) ? '0 : width - 1'b1;
                end
            end
            default: begin
                out_nxt = pol;
                if (cnt_r == '0) begin
                    st_nxt = mgs_pkg::PG_IDLE;
                    out_nxt = !pol;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= mgs_pkg::PG_IDLE;
            cnt_r <= '0;
            out_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end
    assign pout = out_r;

    sequence s_fire;
        st_r == mgs_pkg::PG_IDLE && evt;
    endsequence
    AST_PULSE_START: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        s_fire |=> pout == $past(pol))
        else $error("pulse did not start at active level");
    AST_PULSE_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        (st_r == mgs_pkg::PG_IDLE) && $past(st_r == mgs_pkg::PG_IDLE) |-> pout == !$past(pol))
        else $error("idle pulse level wrong");
endmodule

// ### hdl/mgs_regs.sv
// Purpose: global status and operating mode registers of the meter
// Assumes: host port is synchronous, one access per cycle
// Notes: serial framing and crc generation live outside
//
// Contract
// RULE1: Crystal failure sets status bit 6, ring oscillator takes over.
// RULE2: Power-on reset sets status bit 5.
// RULE3: Host clears the power-on bit after reading it.
// RULE4: Watchdog reset sets bit 4; host writes zero to rearm.
// RULE5: Status bit 2 shows phase order, one for A-C-B.
// RULE6: Status bit 0 shows energy pulse sign, one for reverse.
// RULE7: External clock bit 4 stops crystal, pin becomes clock input.
// RULE8: Restart bit 3 restarts firmware like power-on.
// RULE9: Restart bit clears itself once the restart happened.
// RULE10: Disable bit 2 stops signal processing, supervision continues; code only drives PROC_DISABLE, power calc keeps running.
// RULE11: Low-power bit 1 moves processor clock to 1MHz ring oscillator.
// RULE12: Host reprograms crystal-tuned parameters after entering low power.
// RULE13: CRC bit 3 adds check byte to reads and expects on writes.
// RULE14: Polarity clear: outputs idle high, pulse low one width.
// RULE15: Polarity set: outputs idle low, pulse high one width.
// RULE16: Connection 00: each phase uses own voltage.
// RULE17: Connection 01: phase B uses negated C voltage.
// RULE18: Connection 10: phase B uses negated sum of A and C.
// RULE19: Connection 11: phase B uses A minus C voltage.
// RULE20: Reserved bits read zero, writes to them ignored.
// RULE21: Host writes to device-owned status bits are ignored.
`timescale 1ns/1ps
module mgs_regs #(
    parameter int W = 16,
    parameter int NP = 2
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // Register port
    input wire logic [mgs_pkg::ADDR_W-1:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Status sources
    input wire logic CRYSTAL_FAIL,
    input wire logic POR_EVENT,
    input wire logic WDT_EVENT,
    input wire logic PHASE_REVERSED,
    input wire logic PULSE_REVERSED,
    input wire logic RESTART_DONE,
    // Mode controls
    output logic CRYSTAL_OSC_EN,
    output logic CRYSTAL_PIN_CLKIN,
    output logic FW_RESTART,
    output logic PROC_DISABLE,
    output logic RING_OSC_SEL,
    output logic SERIAL_CHECK_EN,
    // Pulse outputs
    input wire logic [NP-1:0] PULSE_EVENT,
    input wire logic [mgs_pkg::PULSE_W-1:0] PULSE_WIDTH,
    output logic [NP-1:0] ENERGY_PULSE_OUT,
    // Phase data
    input wire logic SAMPLE_VALID,
    input wire logic signed [W-1:0] VOLT_A,
    input wire logic signed [W-1:0] VOLT_B,
    input wire logic signed [W-1:0] VOLT_C,
    input wire logic signed [W-1:0] CURR_A,
    input wire logic signed [W-1:0] CURR_B,
    input wire logic signed [W-1:0] CURR_C,
    output logic POWER_VALID,
    output logic signed [2*W+1:0] POWER_A,
    output logic signed [2*W+1:0] POWER_B,
    output logic signed [2*W+1:0] POWER_C
);
    localparam int PW = 2 * W + 2;

    // ----------------------------------------------------------------
    // Access decode
    // ----------------------------------------------------------------
    logic wr_st, wr_op0, wr_op1;
    assign wr_st = REG_WR && (REG_ADDR == mgs_pkg::ADDR_STATUS);
    assign wr_op0 = REG_WR && (REG_ADDR == mgs_pkg::ADDR_OPM0);
    assign wr_op1 = REG_WR && (REG_ADDR == mgs_pkg::ADDR_OPM1);

    // ----------------------------------------------------------------
    // Status register
    // ----------------------------------------------------------------
    logic xfail_r, xfail_nxt;
    logic por_r, por_nxt;
    logic wdt_r, wdt_nxt;
    logic phase_r, phase_nxt;
    logic prev_r, prev_nxt;

    always_comb begin
        // RULE1: crystal state tracked live
        xfail_nxt = CRYSTAL_FAIL;
        // RULE5: phase order tracked live
        phase_nxt = PHASE_REVERSED;
        // RULE6: pulse sign tracked live
        prev_nxt = PULSE_REVERSED;
        por_nxt = por_r;
        wdt_nxt = wdt_r;
        // RULE21: only cause bits writable
        if (wr_st) begin
            por_nxt = REG_WDATA[mgs_pkg::ST_POR];
            wdt_nxt = REG_WDATA[mgs_pkg::ST_WDT];
        end
        // RULE2: set wins over host write
        if (POR_EVENT) begin
            por_nxt = 1'b1;
        end
        // RULE4: set wins over host clear
        if (WDT_EVENT) begin
            wdt_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            xfail_r <= mgs_pkg::STATUS_RST[mgs_pkg::ST_XFAIL];
            por_r <= mgs_pkg::STATUS_RST[mgs_pkg::ST_POR];
            wdt_r <= mgs_pkg::STATUS_RST[mgs_pkg::ST_WDT];
            phase_r <= mgs_pkg::STATUS_RST[mgs_pkg::ST_PHASE];
            prev_r <= mgs_pkg::STATUS_RST[mgs_pkg::ST_PREV];
        end else begin
            xfail_r <= xfail_nxt;
            por_r <= por_nxt;
            wdt_r <= wdt_nxt;
            phase_r <= phase_nxt;
            prev_r <= prev_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Operating mode registers
    // ----------------------------------------------------------------
    logic external_clock_select_r, external_clock_select_nxt;
    logic software_restart_r, software_restart_nxt;
    logic processing_disable_r, processing_disable_nxt;
    logic low_power_select_r, low_power_select_nxt;
    logic crc_r, crc_nxt;
    logic pol_r, pol_nxt;
    mgs_pkg::mgs_conn_e conn_r, conn_nxt;
    logic osc_en_r, osc_en_nxt;
    logic ring_r, ring_nxt;

    always_comb begin
        external_clock_select_nxt = external_clock_select_r;
        software_restart_nxt = software_restart_r;
        processing_disable_nxt = processing_disable_r;
        low_power_select_nxt = low_power_select_r;
        crc_nxt = crc_r;
        pol_nxt = pol_r;
        conn_nxt = conn_r;
        // RULE9: self clear after restart
        if (RESTART_DONE) begin
            software_restart_nxt = 1'b0;
        end
        // RULE20: reserved bits never stored
        if (wr_op0) begin
            external_clock_select_nxt = REG_WDATA[mgs_pkg::OP0_EXTERNAL_CLOCK_SELECT];
            // RULE8: request firmware restart
            software_restart_nxt = REG_WDATA[mgs_pkg::OP0_SOFTWARE_RESTART];
            processing_disable_nxt = REG_WDATA[mgs_pkg::OP0_PROCESSING_DISABLE];
            low_power_select_nxt = REG_WDATA[mgs_pkg::OP0_LOW_POWER_SELECT];
        end
        if (wr_op1) begin
            crc_nxt = REG_WDATA[mgs_pkg::OP1_CRC];
            pol_nxt = REG_WDATA[mgs_pkg::OP1_POL];
            conn_nxt = mgs_pkg::mgs_conn_e'(REG_WDATA[mgs_pkg::OP1_CONN +: 2]);
        end
        // RULE7: crystal oscillator off in external clock mode
        osc_en_nxt = !external_clock_select_nxt;
        // Fallback also covers a dead crystal, not only low power
        // RULE11: ring oscillator in low power
        ring_nxt = low_power_select_nxt || xfail_nxt;
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            external_clock_select_r <= mgs_pkg::OPM0_RST[mgs_pkg::OP0_EXTERNAL_CLOCK_SELECT];
            software_restart_r <= mgs_pkg::OPM0_RST[mgs_pkg::OP0_SOFTWARE_RESTART];
            processing_disable_r <= mgs_pkg::OPM0_RST[mgs_pkg::OP0_PROCESSING_DISABLE];
            low_power_select_r <= mgs_pkg::OPM0_RST[mgs_pkg::OP0_LOW_POWER_SELECT];
            crc_r <= mgs_pkg::OPM1_RST[mgs_pkg::OP1_CRC];
            pol_r <= mgs_pkg::OPM1_RST[mgs_pkg::OP1_POL];
            conn_r <= mgs_pkg::CONN_BRANCH;
            osc_en_r <= 1'b1;
            ring_r <= 1'b0;
        end else begin
            external_clock_select_r <= external_clock_select_nxt;
            software_restart_r <= software_restart_nxt;
            processing_disable_r <= processing_disable_nxt;
            low_power_select_r <= low_power_select_nxt;
            crc_r <= crc_nxt;
            pol_r <= pol_nxt;
            conn_r <= conn_nxt;
            osc_en_r <= osc_en_nxt;
            ring_r <= ring_nxt;
        end
    end

    assign CRYSTAL_OSC_EN = osc_en_r;
    assign CRYSTAL_PIN_CLKIN = external_clock_select_r;
    assign FW_RESTART = software_restart_r;
    // RULE10: halt flag exported only, power calc keeps running; port still served
    assign PROC_DISABLE = processing_disable_r;
    assign RING_OSC_SEL = ring_r;
    // RULE13: framer appends and checks crc byte
    assign SERIAL_CHECK_EN = crc_r;

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] st_v, op0_v, op1_v;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        st_v = 8'h00;
        st_v[mgs_pkg::ST_XFAIL] = xfail_r;
        st_v[mgs_pkg::ST_POR] = por_r;
        st_v[mgs_pkg::ST_WDT] = wdt_r;
        st_v[mgs_pkg::ST_PHASE] = phase_r;
        st_v[mgs_pkg::ST_PREV] = prev_r;
        op0_v = 8'h00;
        op0_v[mgs_pkg::OP0_EXTERNAL_CLOCK_SELECT] = external_clock_select_r;
        op0_v[mgs_pkg::OP0_SOFTWARE_RESTART] = software_restart_r;
        op0_v[mgs_pkg::OP0_PROCESSING_DISABLE] = processing_disable_r;
        op0_v[mgs_pkg::OP0_LOW_POWER_SELECT] = low_power_select_r;
        op1_v = 8'h00;
        op1_v[mgs_pkg::OP1_CRC] = crc_r;
        op1_v[mgs_pkg::OP1_POL] = pol_r;
        op1_v[mgs_pkg::OP1_CONN +: 2] = conn_r;
        rdata_nxt = rdata_r;
        // RULE20: reserved and unmapped read zero
        if (REG_RD) begin
            if (REG_ADDR == mgs_pkg::ADDR_STATUS) begin
                rdata_nxt = st_v & mgs_pkg::STATUS_MASK;
            end else if (REG_ADDR == mgs_pkg::ADDR_OPM0) begin
                rdata_nxt = op0_v & mgs_pkg::OPM0_MASK;
            end else if (REG_ADDR == mgs_pkg::ADDR_OPM1) begin
                rdata_nxt = op1_v & mgs_pkg::OPM1_MASK;
            end else begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end
    assign REG_RDATA = rdata_r;

    // ----------------------------------------------------------------
    // Pulse outputs and power
    // ----------------------------------------------------------------
    // RULE14: shared polarity drives every output
    for (genvar g = 0; g < NP; g++) begin : g_pulse
        mgs_pulse_gen #(.WW(mgs_pkg::PULSE_W)) u_pg (
            .clk(CLK),
            .rst_n(RESET_N),
            .pol(pol_r),
            .width(PULSE_WIDTH),
            .evt(PULSE_EVENT[g]),
            .pout(ENERGY_PULSE_OUT[g])
        );
    end

    mgs_phase_if #(.W(W)) ph ();
    assign ph.valid = SAMPLE_VALID;
    assign ph.va = VOLT_A;
    assign ph.vb = VOLT_B;
    assign ph.vc = VOLT_C;
    assign ph.ia = CURR_A;
    assign ph.ib = CURR_B;
    assign ph.ic = CURR_C;
    // RULE16: configuration steers the calculator
    assign ph.cfg = conn_r;

    mgs_power_calc u_pc (
        .clk(CLK),
        .rst_n(RESET_N),
        .ph(ph.calc)
    );
    assign POWER_VALID = ph.pvalid;
    assign POWER_A = ph.pa;
    assign POWER_B = ph.pb;
    assign POWER_C = ph.pc;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_restart_wr;
        wr_op0 && REG_WDATA[mgs_pkg::OP0_SOFTWARE_RESTART];
    endsequence
    sequence s_restart_end;
        FW_RESTART && RESTART_DONE && !wr_op0;
    endsequence

    AST_XFAIL_RING: assert property (CRYSTAL_FAIL |=> RING_OSC_SEL) // RULE1
        else $error("crystal failure did not select ring oscillator");
    AST_POR_SET: assert property (POR_EVENT |=> por_r ##1 (por_r || $past(wr_st))) // RULE2
        else $error("power-on cause not held");
    AST_WDT_SET: assert property (WDT_EVENT |=> wdt_r) // RULE4
        else $error("watchdog cause lost");
    AST_WDT_CLR: assert property ( // RULE4
        wr_st && !REG_WDATA[mgs_pkg::ST_WDT] && !WDT_EVENT |=> !wdt_r)
        else $error("watchdog cause not cleared");
    AST_PHASE_RD: assert property ( // RULE5
        REG_RD && REG_ADDR == mgs_pkg::ADDR_STATUS
        |=> REG_RDATA[mgs_pkg::ST_PHASE] == $past(phase_r))
        else $error("phase order read wrong");
    AST_PREV_RD: assert property ( // RULE6
        REG_RD && REG_ADDR == mgs_pkg::ADDR_STATUS
        |=> REG_RDATA[mgs_pkg::ST_PREV] == $past(PULSE_REVERSED, 2))
        else $error("pulse sign read wrong");
    AST_EXTERNAL_CLOCK_SELECT: assert property ( // RULE7
        wr_op0 |=> CRYSTAL_OSC_EN == !$past(REG_WDATA[mgs_pkg::OP0_EXTERNAL_CLOCK_SELECT]))
        else $error("crystal oscillator enable wrong");
    AST_RESTART: assert property (s_restart_wr |=> FW_RESTART) // RULE8
        else $error("restart not requested");
    AST_RESTART_CLR: assert property (s_restart_end |=> !FW_RESTART) // RULE9
        else $error("restart bit not cleared");
    AST_PROCESSING_DISABLE: assert property ( // RULE10
        wr_op0 |=> PROC_DISABLE == $past(REG_WDATA[mgs_pkg::OP0_PROCESSING_DISABLE]))
        else $error("processing disable wrong");
    AST_LOW_POWER_SELECT: assert property ( // RULE11
        wr_op0 && REG_WDATA[mgs_pkg::OP0_LOW_POWER_SELECT] |=> RING_OSC_SEL)
        else $error("low power did not select ring oscillator");
    AST_CRC: assert property ( // RULE13
        wr_op1 |=> SERIAL_CHECK_EN == $past(REG_WDATA[mgs_pkg::OP1_CRC]))
        else $error("crc enable wrong");
    AST_PB_BRANCH: assert property ( // RULE16
        SAMPLE_VALID && conn_r == mgs_pkg::CONN_BRANCH
        |=> POWER_B == PW'($past(CURR_B)) * PW'($past(VOLT_B)))
        else $error("branch power wrong");
    AST_PB_DELTA4: assert property ( // RULE17
        SAMPLE_VALID && conn_r == mgs_pkg::CONN_DELTA4
        |=> POWER_B == PW'($past(CURR_B)) * -PW'($past(VOLT_C)))
        else $error("split leg power wrong");
    AST_PB_WYE2: assert property ( // RULE18
        SAMPLE_VALID && conn_r == mgs_pkg::CONN_WYE2
        |=> POWER_B == PW'($past(CURR_B))
            * (-PW'($past(VOLT_A)) - PW'($past(VOLT_C))))
        else $error("two sensor power wrong");
    AST_PB_DELTA3: assert property ( // RULE19
        SAMPLE_VALID && conn_r == mgs_pkg::CONN_DELTA3
        |=> POWER_B == PW'($past(CURR_B))
            * (PW'($past(VOLT_A)) - PW'($past(VOLT_C))))
        else $error("delta power wrong");
    AST_RSVD_RD: assert property ( // RULE20
        REG_RD && REG_ADDR == mgs_pkg::ADDR_OPM0
        |=> (REG_RDATA & ~mgs_pkg::OPM0_MASK) == 8'h00)
        else $error("reserved bits read nonzero");
    AST_STATUS_RO: assert property ( // RULE21
        wr_st |=> xfail_r == $past(CRYSTAL_FAIL) && phase_r == $past(PHASE_REVERSED))
        else $error("device status bit took host write");
endmodule
